// ---- rtl/sto_pkg.sv ----
// constants and types for the control-terminal run and torque-disable logic
package sto_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TEST_PULSE_MAX_NS = 3000000;
  // mismatch must outlast the longest test pulse, so one cycle beyond it
  localparam int MISMATCH_CYCLES = TEST_PULSE_MAX_NS / CLK_PERIOD_NS + 1;
  localparam logic [7:0] TRIP_CODE_STO = 8'h23;
  localparam logic [7:0] TRIP_CODE_NONE = 8'h00;
  localparam logic SYNC_RESET = 1'b0;
  localparam logic CHAN_OPEN_RESET = 1'b1;
  typedef enum logic [1:0] {
    REF_VOLTAGE,
    REF_CURRENT,
    REF_PRESET_TWO,
    REF_PARAMETER
  } ref_source_t;
  typedef enum logic [1:0] {
    MODE_FWD_REV,
    MODE_LATCHED,
    MODE_RUN_DIR,
    MODE_SPARE
  } run_mode_t;
endpackage : sto_pkg

// ---- rtl/sto_chan_if.sv ----
// link carrying one synchronised torque-disable channel to the control logic
`timescale 1ns/10ps
interface sto_chan_if;
  logic open_q;
  modport chan (output open_q);
  modport ctrl (input open_q);
endinterface : sto_chan_if

// ---- rtl/sto_channel.sv ----
// one torque-disable input: two-stage synchroniser producing an open flag
`timescale 1ns/10ps
module sto_channel (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin_in,
  sto_chan_if.chan ch
);
  import sto_pkg::*;
  logic meta_q;

  // first stage only feeds the second; a reset reads as open for safety
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_q <= SYNC_RESET;
      ch.open_q <= CHAN_OPEN_RESET;
    end else begin
      meta_q <= pin_in;
      ch.open_q <= ~meta_q;
    end
  end
endmodule : sto_channel

// ---- rtl/run_control.sv ----
// run/stop decode, reference select and two-channel torque-disable interlock
`timescale 1ns/10ps
module run_control #(
  parameter int MISMATCH_LIMIT = sto_pkg::MISMATCH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic torque_disable_in_a,
  input wire logic torque_disable_in_b,
  input wire logic ref_select_in_lo,
  input wire logic ref_select_in_hi,
  input wire logic run_cmd_in,
  input wire logic stop_dir_cmd_in,
  input wire logic motor_thermal_in,
  input wire sto_pkg::run_mode_t run_mode,
  input wire logic thermal_src_terminal,
  input wire logic brake_req,
  input wire logic trip_clear,
  output sto_pkg::ref_source_t ref_source_q,
  output logic bridge_lock_a_q,
  output logic bridge_lock_b_q,
  output logic brake_enable_q,
  output logic drive_status_relay_q,
  output logic trip_q,
  output logic [7:0] trip_code_q,
  output logic run_fwd_q,
  output logic run_rev_q,
  output logic thermal_detect_en_q,
  output logic thermal_fault_q
);
  import sto_pkg::*;
  localparam int CW = $clog2(MISMATCH_LIMIT + 1);
  localparam int NPIN = 5;

  sto_chan_if chan_a ();
  sto_chan_if chan_b ();
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] pin_q;
  logic [CW-1:0] mis_cnt_q;
  logic mismatch;
  logic mis_expired;
  logic any_open;
  logic run_prev_q;
  logic run_latch_q;
  logic want_fwd;
  logic want_rev;
  logic sel_lo;
  logic sel_hi;
  logic run_s;
  logic stop_s;
  logic therm_s;

  // each channel is synchronised on its own, no shared path
  sto_channel u_chan_a (.clk_sys(clk_sys), .rst_b(rst_b), .pin_in(torque_disable_in_a),
    .ch(chan_a.chan));
  sto_channel u_chan_b (.clk_sys(clk_sys), .rst_b(rst_b), .pin_in(torque_disable_in_b),
    .ch(chan_b.chan));

  // terminal inputs cross two flops before any logic reads them
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_q <= '0;
      pin_q <= '0;
    end else begin
      meta_q <= {motor_thermal_in, stop_dir_cmd_in, run_cmd_in, ref_select_in_hi,
        ref_select_in_lo};
      pin_q <= meta_q;
    end
  end
  assign sel_lo = pin_q[0];
  assign sel_hi = pin_q[1];
  assign run_s = pin_q[2];
  assign stop_s = pin_q[3];
  assign therm_s = pin_q[4];

  // reference source follows the two select inputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ref_source_q <= REF_VOLTAGE;
    end else begin
      ref_source_q <= ref_source_t'({sel_lo, sel_hi});
    end
  end

  // each lock stage follows its own channel one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bridge_lock_a_q <= 1'b1;
      bridge_lock_b_q <= 1'b1;
    end else begin
      bridge_lock_a_q <= chan_a.open_q;
      bridge_lock_b_q <= chan_b.open_q;
    end
  end

  assign any_open = chan_a.open_q | chan_b.open_q;
  assign mismatch = chan_a.open_q ^ chan_b.open_q;
  assign mis_expired = (mis_cnt_q == CW'(MISMATCH_LIMIT));

  // disagreement is timed; a test pulse ends before the limit and is forgiven
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mis_cnt_q <= '0;
    end else if (!mismatch) begin
      mis_cnt_q <= '0;
    end else if (!mis_expired) begin
      mis_cnt_q <= mis_cnt_q + CW'(1);
    end
  end

  // trip is sticky; a fresh mismatch wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      trip_q <= 1'b0;
      trip_code_q <= TRIP_CODE_NONE;
    end else if (mismatch && mis_expired) begin
      trip_q <= 1'b1;
      trip_code_q <= TRIP_CODE_STO;
    end else if (trip_clear && !mismatch) begin
      trip_q <= 1'b0;
      trip_code_q <= TRIP_CODE_NONE;
    end
  end

  // relay closes only with both channels closed and no trip pending
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drive_status_relay_q <= 1'b0;
    end else begin
      drive_status_relay_q <= !any_open && !trip_q && !(mismatch && mis_expired);
    end
  end

  // braking needs the bridge, so it is withdrawn whenever a lock applies
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      brake_enable_q <= 1'b0;
    end else begin
      brake_enable_q <= brake_req && !any_open;
    end
  end

  // latched run: rising run edge sets, stop input low releases, stop wins
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      run_prev_q <= 1'b0;
      run_latch_q <= 1'b0;
    end else begin
      run_prev_q <= run_s;
      if (run_mode != MODE_LATCHED || !stop_s) begin
        run_latch_q <= 1'b0;
      end else if (run_s && !run_prev_q) begin
        run_latch_q <= 1'b1;
      end
    end
  end

  // command decode per wiring mode
  always_comb begin
    want_fwd = 1'b0;
    want_rev = 1'b0;
    case (run_mode)
      MODE_FWD_REV: begin
        want_fwd = run_s && !stop_s;
        want_rev = stop_s && !run_s;
      end
      MODE_LATCHED: begin
        want_fwd = run_latch_q;
      end
      MODE_RUN_DIR: begin
        want_fwd = run_s && !stop_s;
        want_rev = run_s && stop_s;
      end
      default: begin
        want_fwd = 1'b0;
        want_rev = 1'b0;
      end
    endcase
  end

  // run is only granted with both inputs closed, as the controller must arrange
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      run_fwd_q <= 1'b0;
      run_rev_q <= 1'b0;
    end else begin
      run_fwd_q <= want_fwd && !any_open && !trip_q;
      run_rev_q <= want_rev && !any_open && !trip_q;
    end
  end

  // thermal sensor ignored until its source is set to the drive terminal
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      thermal_detect_en_q <= 1'b0;
      thermal_fault_q <= 1'b0;
    end else begin
      thermal_detect_en_q <= thermal_src_terminal;
      thermal_fault_q <= thermal_src_terminal && therm_s;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_lock_chan_a: assert property (chan_a.open_q |=> bridge_lock_a_q)
    else $error("lock a did not follow open channel a");
  chk_lock_chan_b: assert property (chan_b.open_q |=> bridge_lock_b_q)
    else $error("lock b did not follow open channel b");
  chk_relay_on_open: assert property (any_open |=> !drive_status_relay_q)
    else $error("status relay closed with a channel open");
  chk_trip_code_value: assert property (trip_q |-> trip_code_q == TRIP_CODE_STO)
    else $error("trip without code 35");
  chk_trip_cause_time: assert property ($rose(trip_q) |-> $past(mismatch) && $past(mis_expired))
    else $error("trip without an expired mismatch");
  chk_pulse_no_trip: assert property (mismatch && !mis_expired |=> !$rose(trip_q))
    else $error("short test pulse caused a trip");
  chk_brake_when_locked: assert property ((bridge_lock_a_q || bridge_lock_b_q)
    |-> !brake_enable_q)
    else $error("braking while bridge locked");
  chk_ref_select_map: assert property (##1 ref_source_q == ref_source_t'($past({sel_lo, sel_hi})))
    else $error("reference source does not follow select inputs");
  chk_run_needs_close: assert property ((run_fwd_q || run_rev_q) |-> $past(!any_open))
    else $error("run granted with a channel open");
  chk_dir_mode_rev: assert property (run_mode == MODE_RUN_DIR && run_s && stop_s && !any_open
    && !trip_q |=> run_rev_q && !run_fwd_q)
    else $error("direction mode reverse not decoded");
  chk_thermal_gate: assert property (!thermal_detect_en_q |-> !thermal_fault_q)
    else $error("thermal fault while detection disabled");
  chk_latch_release: assert property (run_mode == MODE_LATCHED && !stop_s |=> !run_latch_q)
    else $error("stop input did not release latched run");
endmodule : run_control

// ---- sim/sto_partner.sv ----
// terminal-side model: safety controller outputs with bounded self-test pulses
`timescale 1ns/10ps
module sto_partner #(
  parameter int PULSE_MAX = 20
) (
  input wire logic clk_sys,
  input wire logic close_a,
  input wire logic close_b,
  input wire logic pulse_go,
  output logic torque_disable_in_a,
  output logic torque_disable_in_b
);
  int cnt_q = 0;
  // pulse timer; a request while busy is dropped so a pulse never stretches
  always_ff @(posedge clk_sys) begin
    if (pulse_go && cnt_q == 0) begin
      cnt_q <= PULSE_MAX;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // channel a dips low during a test pulse, channel b is a plain switch
  assign torque_disable_in_a = close_a && cnt_q == 0;
  assign torque_disable_in_b = close_b;
endmodule : sto_partner

// ---- sim/test_run_control.sv ----
// self-checking bench for run control and the torque-disable interlock
`timescale 1ns/10ps
module test_run_control;
  import sto_pkg::*;
  localparam int LIM = 20;
  typedef struct {int when; int k; logic [7:0] v;} note_t;
  note_t q[$];
  string nm[11] = '{"ref", "lock_a", "lock_b", "brake", "relay", "trip", "code", "fwd", "rev",
    "th_en", "th_flt"};
  logic clk_sys = 1'b0, rst_b = 1'b0, close_a = 1'b0, close_b = 1'b0, pulse_go = 1'b0;
  logic torque_disable_in_a, torque_disable_in_b, ref_select_in_lo = 1'b0;
  logic ref_select_in_hi = 1'b0, run_cmd_in = 1'b0, stop_dir_cmd_in = 1'b0;
  logic motor_thermal_in = 1'b0, thermal_src_terminal = 1'b0, brake_req = 1'b0;
  logic trip_clear = 1'b0;
  run_mode_t run_mode = MODE_FWD_REV;
  ref_source_t ref_source_q;
  logic bridge_lock_a_q, bridge_lock_b_q, brake_enable_q, drive_status_relay_q, trip_q;
  logic run_fwd_q, run_rev_q, thermal_detect_en_q, thermal_fault_q;
  logic [7:0] trip_code_q;
  int cyc = 0, fail_count = 0, n_tests = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  sto_partner #(.PULSE_MAX(LIM)) u_far (.clk_sys, .close_a, .close_b, .pulse_go,
    .torque_disable_in_a, .torque_disable_in_b);
  // short limit keeps the mismatch window to twenty cycles in simulation
  run_control #(.MISMATCH_LIMIT(LIM)) u_dut (.clk_sys, .rst_b, .torque_disable_in_a,
    .torque_disable_in_b, .ref_select_in_lo, .ref_select_in_hi, .run_cmd_in,
    .stop_dir_cmd_in, .motor_thermal_in, .run_mode, .thermal_src_terminal, .brake_req,
    .trip_clear, .ref_source_q, .bridge_lock_a_q, .bridge_lock_b_q, .brake_enable_q,
    .drive_status_relay_q, .trip_q, .trip_code_q, .run_fwd_q, .run_rev_q,
    .thermal_detect_en_q, .thermal_fault_q);
  function automatic logic [7:0] seen(int k);
    case (k)
      0: return 8'(ref_source_q);
      1: return 8'(bridge_lock_a_q);
      2: return 8'(bridge_lock_b_q);
      3: return 8'(brake_enable_q);
      4: return 8'(drive_status_relay_q);
      5: return 8'(trip_q);
      6: return trip_code_q;
      7: return 8'(run_fwd_q);
      8: return 8'(run_rev_q);
      9: return 8'(thermal_detect_en_q);
      default: return 8'(thermal_fault_q);
    endcase
  endfunction : seen
  // notes fall due on the falling edge, well clear of the design's updates
  always @(negedge clk_sys) begin
    cyc = cyc + 1;
    while (q.size() != 0 && q[0].when <= cyc) begin
      n_tests++;
      if (seen(q[0].k) !== q[0].v) begin
        fail_count++;
        $display("[FAIL] %s exp %h seen %h", nm[q[0].k], q[0].v, seen(q[0].k));
      end
      void'(q.pop_front());
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic note(int d, int k, logic [7:0] v);
    q.push_back('{cyc + d, k, v});
  endtask : note
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // watchdog: a hung sequence counts as a mismatch
  initial begin
    tick(5000);
    fail_count++;
    test_done();
  end
  initial begin
    logic [1:0] code;
    void'($urandom(94));
    tick(20);
    rst_b <= 1'b1;
    note(1, 1, 8'h01);
    note(1, 4, 8'h00);
    note(1, 9, 8'h00);
    close_a <= 1'b1;
    close_b <= 1'b1;
    note(6, 1, 8'h00);
    note(6, 4, 8'h01);
    tick(7);
    // every select code once, then random ones
    for (int i = 0; i < 8; i++) begin
      code = (i < 4) ? 2'(i) : 2'($urandom);
      ref_select_in_lo <= code[1];
      ref_select_in_hi <= code[0];
      note(5, 0, 8'(code));
      tick(6);
    end
    run_mode <= MODE_RUN_DIR;
    run_cmd_in <= 1'b1;
    stop_dir_cmd_in <= 1'b1;
    note(5, 8, 8'h01);
    tick(6);
    stop_dir_cmd_in <= 1'b0;
    note(5, 7, 8'h01);
    note(5, 8, 8'h00);
    tick(6);
    run_cmd_in <= 1'b0;
    run_mode <= MODE_LATCHED;
    stop_dir_cmd_in <= 1'b1;
    note(5, 7, 8'h00);
    tick(6);
    // a one-cycle run pulse must stay latched after it ends
    run_cmd_in <= 1'b1;
    tick(1);
    run_cmd_in <= 1'b0;
    note(8, 7, 8'h01);
    tick(9);
    stop_dir_cmd_in <= 1'b0;
    brake_req <= 1'b1;
    note(6, 7, 8'h00);
    note(6, 3, 8'h01);
    tick(7);
    pulse_go <= 1'b1;
    tick(1);
    pulse_go <= 1'b0;
    note(7, 1, 8'h01);
    note(7, 2, 8'h00);
    note(7, 4, 8'h00);
    note(7, 3, 8'h00);
    note(32, 5, 8'h00);
    note(32, 4, 8'h01);
    tick(33);
    close_a <= 1'b0;
    note(20, 5, 8'h00);
    note(40, 5, 8'h01);
    note(40, 6, 8'h23);
    note(40, 4, 8'h00);
    tick(41);
    close_a <= 1'b1;
    note(6, 5, 8'h01);
    tick(7);
    trip_clear <= 1'b1;
    tick(1);
    trip_clear <= 1'b0;
    note(5, 5, 8'h00);
    note(5, 6, 8'h00);
    motor_thermal_in <= 1'b1;
    note(6, 10, 8'h00);
    tick(7);
    thermal_src_terminal <= 1'b1;
    note(5, 9, 8'h01);
    note(5, 10, 8'h01);
    tick(8);
    // factory two-input mode: run forward, both inputs stop, reverse alone
    run_mode <= MODE_FWD_REV;
    run_cmd_in <= 1'b1;
    note(5, 7, 8'h01);
    tick(6);
    stop_dir_cmd_in <= 1'b1;
    note(5, 7, 8'h00);
    note(5, 8, 8'h00);
    tick(6);
    run_cmd_in <= 1'b0;
    note(5, 8, 8'h01);
    tick(6);
    // spare mode must never grant a run
    run_mode <= MODE_SPARE;
    note(3, 8, 8'h00);
    note(3, 7, 8'h00);
    tick(4);
    test_done();
  end
endmodule : test_run_control
